// [rtl/sms_cmd_seq.sv]
// top: command sequencer for fetch, configure, read and measure with AHB-Lite registers
//
// Overview of operation
// R1 - fetch queues the latest reading; no measurement, no setup change
// R2 - with no new reading, each fetch returns the same old reading again
// R3 - configure selects volts, amps, ohms or coulombs and defaults its controls
// R4 - configure clears continuous initiation
// R5 - configure sets every layer's event source to immediate
// R6 - configure sets every layer count to one and delay to zero
// R7 - configure idles the model, disables math and buffer, aborts storage
// R8 - configure defaults autozero, sets normal acquisition, disables scanning
// R9 - configure query reports the selected function
// R10 - read runs abort, then initiate, then fetch, in that order
// R11 - in one-shot mode each read converts afresh and returns that reading
// R12 - abort idles with continuous initiation off, else restarts the model
// R13 - initiate leaves idle; with continuous initiation on it errors and is ignored
// R14 - an ignored initiate inside read still lets the fetch run
// R15 - measure runs abort, configure, then the read's initiate and fetch
// R16 - host addresses the device to talk to collect the queued reading
// R17 - initiate is overlapped; it completes when the model is idle again
// R18 - after the single one-shot conversion the model returns to idle
`timescale 1ns/10ps
module sms_cmd_seq #(
    parameter int unsigned RDG_W = 32
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic conv_done_i,
    input wire logic [RDG_W-1:0] conv_data_i,
    input wire logic ext_trig_i,
    output logic conv_start_o,
    output sms_pkg::sms_setup_t setup_o,
    output logic store_abort_o,
    output logic irq_o
);
    // bus data-phase state
    logic wr_ph_ff;
    logic [sms_pkg::ADDR_W-1:0] wr_addr_ff;

    // software visible state
    sms_pkg::sms_trig_cfg_t tcfg_ff;
    logic [sms_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [sms_pkg::IRQ_W-1:0] irq_mask_ff;
    sms_pkg::sms_op_t op_ff;
    sms_pkg::sms_func_t fn_ff;
    sms_pkg::sms_seq_t sq_ff;
    logic tm_idle_q_ff;

    // decoded cycle events
    logic addr_ph;
    logic rd_pop;
    logic wr_cmd;
    logic cmd_go;
    logic abort_go;
    logic conf_go;
    logic init_go;
    logic fetch_go;
    logic confq_go;
    logic init_err;
    logic tm_idle;
    logic mav;
    logic fresh;
    logic [RDG_W-1:0] queue_word;
    logic [31:0] rd_word;
    logic [sms_pkg::IRQ_W-1:0] irq_set;
    logic [sms_pkg::IRQ_W-1:0] irq_clr;
    sms_pkg::sms_op_t wr_op;

    generate
        if (RDG_W < 2 || RDG_W > 32) begin : g_bad_width
            $error("reading width must be 2 to 32");
        end
    endgenerate

    // ---------------- bus slave ----------------
    assign addr_ph = hsel_i && htrans_i[1] && hready_i;
    // a read of the data register is the host taking the queued message
    assign rd_pop = addr_ph && !hwrite_i && (haddr_i[sms_pkg::ADDR_W-1:0] == sms_pkg::OFS_DATA); // R16
    assign wr_cmd = wr_ph_ff && (wr_addr_ff == sms_pkg::OFS_CMD);
    assign wr_op = sms_pkg::sms_op_t'(hwdata_i[sms_pkg::CMD_OP_LSB +: 3]);
    assign cmd_go = wr_cmd && (sq_ff == sms_pkg::SQ_IDLE) && (wr_op != sms_pkg::OP_NONE);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ph_ff <= 1'b0;
            wr_addr_ff <= '0;
        end else begin
            wr_ph_ff <= addr_ph && hwrite_i;
            if (addr_ph) begin
                wr_addr_ff <= haddr_i[sms_pkg::ADDR_W-1:0];
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr_i[sms_pkg::ADDR_W-1:0])
            sms_pkg::OFS_CMD: begin
                rd_word[sms_pkg::CMD_OP_LSB +: 3] = op_ff;
                rd_word[sms_pkg::CMD_FN_LSB +: 2] = fn_ff;
            end
            sms_pkg::OFS_SETUP: begin
                rd_word[sms_pkg::SETUP_W-1:0] = setup_o;
            end
            sms_pkg::OFS_TSRC: begin
                rd_word[sms_pkg::NLAYER-1:0] = tcfg_ff.ext_src;
            end
            sms_pkg::OFS_TCNT: begin
                rd_word[sms_pkg::NLAYER*sms_pkg::TCNT_W-1:0] = tcfg_ff.cnt;
            end
            sms_pkg::OFS_TDLY: begin
                rd_word[sms_pkg::NLAYER*sms_pkg::TCNT_W-1:0] = tcfg_ff.dly;
            end
            sms_pkg::OFS_STATUS: begin
                rd_word[sms_pkg::ST_BUSY] = (sq_ff != sms_pkg::SQ_IDLE);
                rd_word[sms_pkg::ST_IDLE] = tm_idle;
                rd_word[sms_pkg::ST_MAV] = mav;
                rd_word[sms_pkg::ST_FRESH] = fresh;
                rd_word[sms_pkg::ST_FN_LSB +: 2] = setup_o.func;
            end
            sms_pkg::OFS_DATA: begin
                rd_word[RDG_W-1:0] = queue_word;
            end
            sms_pkg::OFS_IRQ_STAT: begin
                rd_word[sms_pkg::IRQ_W-1:0] = irq_stat_ff;
            end
            sms_pkg::OFS_IRQ_MASK: begin
                rd_word[sms_pkg::IRQ_W-1:0] = irq_mask_ff;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // zero wait state: read data is registered at the address phase edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (addr_ph && !hwrite_i) begin
                hrdata_o <= rd_word;
            end
        end
    end

    // ---------------- command sequencer ----------------
    assign abort_go = (sq_ff == sms_pkg::SQ_ABORT);
    assign conf_go = (sq_ff == sms_pkg::SQ_CONF);
    assign init_go = (sq_ff == sms_pkg::SQ_INIT);
    assign fetch_go = (sq_ff == sms_pkg::SQ_FETCH) && (op_ff != sms_pkg::OP_CONFQ);
    assign confq_go = (sq_ff == sms_pkg::SQ_FETCH) && (op_ff == sms_pkg::OP_CONFQ);
    assign init_err = init_go && setup_o.cont_init; // R13

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_ff <= sms_pkg::OP_NONE;
            fn_ff <= sms_pkg::FN_VOLT;
        end else if (cmd_go) begin
            op_ff <= wr_op;
            fn_ff <= sms_pkg::sms_func_t'(hwdata_i[sms_pkg::CMD_FN_LSB +: 2]);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sq_ff <= sms_pkg::SQ_IDLE;
        end else begin
            case (sq_ff)
                sms_pkg::SQ_IDLE: begin
                    if (cmd_go) begin
                        case (wr_op)
                            sms_pkg::OP_FETCH: sq_ff <= sms_pkg::SQ_FETCH; // R1
                            sms_pkg::OP_CONFQ: sq_ff <= sms_pkg::SQ_FETCH;
                            sms_pkg::OP_CONF: sq_ff <= sms_pkg::SQ_CONF;
                            sms_pkg::OP_INIT: sq_ff <= sms_pkg::SQ_INIT;
                            sms_pkg::OP_READ: sq_ff <= sms_pkg::SQ_ABORT; // R10
                            sms_pkg::OP_MEAS: sq_ff <= sms_pkg::SQ_ABORT; // R15
                            sms_pkg::OP_ABORT: sq_ff <= sms_pkg::SQ_ABORT;
                            default: sq_ff <= sms_pkg::SQ_IDLE;
                        endcase
                    end
                end
                sms_pkg::SQ_ABORT: begin
                    case (op_ff)
                        sms_pkg::OP_MEAS: sq_ff <= sms_pkg::SQ_CONF; // R15
                        sms_pkg::OP_READ: sq_ff <= sms_pkg::SQ_INIT; // R10
                        default: sq_ff <= sms_pkg::SQ_IDLE;
                    endcase
                end
                sms_pkg::SQ_CONF: begin
                    sq_ff <= (op_ff == sms_pkg::OP_MEAS) ? sms_pkg::SQ_INIT : sms_pkg::SQ_IDLE;
                end
                sms_pkg::SQ_INIT: begin
                    // a stand-alone initiate is overlapped and frees the sequencer at once
                    if (op_ff == sms_pkg::OP_INIT) begin
                        sq_ff <= sms_pkg::SQ_IDLE; // R17
                    end else if (setup_o.cont_init) begin
                        sq_ff <= sms_pkg::SQ_FETCH; // R14
                    end else begin
                        sq_ff <= sms_pkg::SQ_WAIT;
                    end
                end
                sms_pkg::SQ_WAIT: begin
                    // the one conversion lands on the same edge as the model reports idle
                    if (tm_idle) begin
                        sq_ff <= sms_pkg::SQ_FETCH; // R11
                    end
                end
                sms_pkg::SQ_FETCH: begin
                    sq_ff <= sms_pkg::SQ_IDLE;
                end
                default: begin
                    sq_ff <= sms_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // ---------------- setup and trigger configuration ----------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            setup_o <= sms_pkg::SETUP_RST;
        end else if (conf_go) begin
            setup_o <= sms_pkg::SETUP_RST; // R3 R7 R8
            setup_o.func <= fn_ff; // R3
            setup_o.cont_init <= 1'b0; // R4
        end else if (wr_ph_ff && (wr_addr_ff == sms_pkg::OFS_SETUP)) begin
            setup_o <= sms_pkg::sms_setup_t'(hwdata_i[sms_pkg::SETUP_W-1:0]);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tcfg_ff <= sms_pkg::TRIG_ONESHOT;
        end else if (conf_go) begin
            tcfg_ff <= sms_pkg::TRIG_ONESHOT; // R5 R6
        end else if (wr_ph_ff) begin
            case (wr_addr_ff)
                sms_pkg::OFS_TSRC: tcfg_ff.ext_src <= hwdata_i[sms_pkg::NLAYER-1:0];
                sms_pkg::OFS_TCNT: tcfg_ff.cnt <= hwdata_i[sms_pkg::NLAYER*sms_pkg::TCNT_W-1:0];
                sms_pkg::OFS_TDLY: tcfg_ff.dly <= hwdata_i[sms_pkg::NLAYER*sms_pkg::TCNT_W-1:0];
                default: tcfg_ff <= tcfg_ff;
            endcase
        end
    end

    // storage is aborted for one cycle whenever configure runs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            store_abort_o <= 1'b0;
        end else begin
            store_abort_o <= conf_go; // R7
        end
    end

    // ---------------- trigger model and reading store ----------------
    sms_trig_model u_trig (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .cfg_i(tcfg_ff),
        .cont_i(setup_o.cont_init && !conf_go),
        .init_i(init_go && !setup_o.cont_init),
        .abort_i(abort_go || conf_go), // R7 R12
        .ext_trig_i(ext_trig_i),
        .conv_done_i(conv_done_i),
        .conv_start_o(conv_start_o),
        .idle_o(tm_idle)
    );

    sms_reading_store #(
        .RDG_W(RDG_W)
    ) u_store (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i),
        .fetch_i(fetch_go),
        .func_q_i(confq_go),
        .func_i(setup_o.func),
        .pop_i(rd_pop),
        .queue_o(queue_word),
        .mav_o(mav),
        .fresh_o(fresh)
    );

    // ---------------- interrupts ----------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tm_idle_q_ff <= 1'b1;
        end else begin
            tm_idle_q_ff <= tm_idle;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[sms_pkg::IRQ_MAV] = fetch_go || confq_go;
        irq_set[sms_pkg::IRQ_INIT_ERR] = init_err;
        irq_set[sms_pkg::IRQ_OP_DONE] = tm_idle && !tm_idle_q_ff; // R17
        irq_set[sms_pkg::IRQ_DROP] = wr_cmd && (sq_ff != sms_pkg::SQ_IDLE);
        irq_clr = '0;
        if (wr_ph_ff && (wr_addr_ff == sms_pkg::OFS_IRQ_STAT)) begin
            irq_clr = hwdata_i[sms_pkg::IRQ_W-1:0];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_ff <= sms_pkg::IRQ_RST;
            irq_mask_ff <= sms_pkg::IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            if (wr_ph_ff && (wr_addr_ff == sms_pkg::OFS_IRQ_MASK)) begin
                irq_mask_ff <= hwdata_i[sms_pkg::IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end
endmodule

// [rtl/sms_pkg.sv]
// constants, types and register map of the one-shot measurement command sequencer
package sms_pkg;

    // register byte offsets on the bus
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_SETUP = 8'h04;
    localparam logic [7:0] OFS_TSRC = 8'h08;
    localparam logic [7:0] OFS_TCNT = 8'h0C;
    localparam logic [7:0] OFS_TDLY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_DATA = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // command register fields
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_FN_LSB = 4;

    // status register fields
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_IDLE = 1;
    localparam int unsigned ST_MAV = 2;
    localparam int unsigned ST_FRESH = 3;
    localparam int unsigned ST_FN_LSB = 4;

    // interrupt status bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_MAV = 0;
    localparam int unsigned IRQ_INIT_ERR = 1;
    localparam int unsigned IRQ_OP_DONE = 2;
    localparam int unsigned IRQ_DROP = 3;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // trigger model shape
    localparam int unsigned NLAYER = 3;
    localparam int unsigned TCNT_W = 8;
    localparam logic [TCNT_W-1:0] TCNT_ONE = 8'h01;
    localparam logic [TCNT_W-1:0] TDLY_ZERO = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_FETCH = 3'b001,
        OP_CONF = 3'b010,
        OP_READ = 3'b011,
        OP_MEAS = 3'b100,
        OP_ABORT = 3'b101,
        OP_INIT = 3'b110,
        OP_CONFQ = 3'b111
    } sms_op_t;

    typedef enum logic [1:0] {
        FN_VOLT = 2'b00,
        FN_AMP = 2'b01,
        FN_OHM = 2'b10,
        FN_COUL = 2'b11
    } sms_func_t;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_ABORT = 3'b001,
        SQ_CONF = 3'b010,
        SQ_INIT = 3'b011,
        SQ_WAIT = 3'b100,
        SQ_FETCH = 3'b101
    } sms_seq_t;

    typedef enum logic [2:0] {
        TM_IDLE = 3'b000,
        TM_EVT = 3'b001,
        TM_DLY = 3'b010,
        TM_CONV = 3'b011,
        TM_WCONV = 3'b100
    } sms_tm_t;

    // setup state, high bits first in the register
    typedef struct packed {
        logic [3:0] range_sel;
        logic scan_en;
        logic acq_avg;
        logic az_en;
        logic buf_en;
        logic math_en;
        logic cont_init;
        sms_func_t func;
    } sms_setup_t;

    typedef struct packed {
        logic [NLAYER-1:0] ext_src;
        logic [NLAYER-1:0][TCNT_W-1:0] cnt;
        logic [NLAYER-1:0][TCNT_W-1:0] dly;
    } sms_trig_cfg_t;

    localparam int unsigned SETUP_W = 12;
    localparam sms_setup_t SETUP_RST = '{range_sel: 4'h0, scan_en: 1'b0, acq_avg: 1'b0, az_en: 1'b1,
        buf_en: 1'b0, math_en: 1'b0, cont_init: 1'b0, func: FN_VOLT};
    localparam sms_trig_cfg_t TRIG_ONESHOT = '{ext_src: 3'h0, cnt: {NLAYER{TCNT_ONE}},
        dly: {NLAYER{TDLY_ZERO}}};

endpackage

// [rtl/sms_trig_model.sv]
// three-layer trigger model: event wait and delay per layer, conversion after the third layer
`timescale 1ns/10ps
module sms_trig_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input sms_pkg::sms_trig_cfg_t cfg_i,
    input wire logic cont_i,
    input wire logic init_i,
    input wire logic abort_i,
    input wire logic ext_trig_i,
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic idle_o
);
    sms_pkg::sms_tm_t state_ff;
    logic [1:0] lyr_ff;
    logic [sms_pkg::TCNT_W-1:0] dly_ff;
    logic [sms_pkg::NLAYER-1:0][sms_pkg::TCNT_W-1:0] left_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= sms_pkg::TM_IDLE;
            lyr_ff <= 2'h0;
            dly_ff <= '0;
            left_ff <= '0;
            conv_start_o <= 1'b0;
            idle_o <= 1'b1;
        end else begin
            conv_start_o <= 1'b0;
            if (abort_i) begin
                // abort: idle without re-arm, else restart at the top layer
                lyr_ff <= 2'h0;
                left_ff <= cfg_i.cnt;
                state_ff <= cont_i ? sms_pkg::TM_EVT : sms_pkg::TM_IDLE; // R12
                idle_o <= !cont_i;
            end else begin
                case (state_ff)
                    sms_pkg::TM_IDLE: begin
                        if (init_i) begin
                            lyr_ff <= 2'h0;
                            left_ff <= cfg_i.cnt;
                            state_ff <= sms_pkg::TM_EVT; // R13
                            idle_o <= 1'b0;
                        end
                    end
                    sms_pkg::TM_EVT: begin
                        if (!cfg_i.ext_src[lyr_ff] || ext_trig_i) begin
                            dly_ff <= cfg_i.dly[lyr_ff];
                            state_ff <= sms_pkg::TM_DLY;
                        end
                    end
                    sms_pkg::TM_DLY: begin
                        if (dly_ff != '0) begin
                            dly_ff <= dly_ff - 1'b1;
                        end else if (lyr_ff == 2'h2) begin
                            state_ff <= sms_pkg::TM_CONV;
                        end else begin
                            lyr_ff <= lyr_ff + 2'h1;
                            state_ff <= sms_pkg::TM_EVT;
                        end
                    end
                    sms_pkg::TM_CONV: begin
                        conv_start_o <= 1'b1;
                        state_ff <= sms_pkg::TM_WCONV;
                    end
                    sms_pkg::TM_WCONV: begin
                        if (conv_done_i) begin
                            state_ff <= sms_pkg::TM_EVT;
                            if (left_ff[2] > sms_pkg::TCNT_ONE) begin
                                left_ff[2] <= left_ff[2] - 1'b1;
                                lyr_ff <= 2'h2;
                            end else if (left_ff[1] > sms_pkg::TCNT_ONE) begin
                                left_ff[1] <= left_ff[1] - 1'b1;
                                left_ff[2] <= cfg_i.cnt[2];
                                lyr_ff <= 2'h1;
                            end else if (left_ff[0] > sms_pkg::TCNT_ONE) begin
                                left_ff[0] <= left_ff[0] - 1'b1;
                                left_ff[2:1] <= cfg_i.cnt[2:1];
                                lyr_ff <= 2'h0;
                            end else if (cont_i) begin
                                left_ff <= cfg_i.cnt;
                                lyr_ff <= 2'h0;
                            end else begin
                                state_ff <= sms_pkg::TM_IDLE; // R18
                                idle_o <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state_ff <= sms_pkg::TM_IDLE;
                        idle_o <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// [rtl/sms_reading_store.sv]
// latest post-processed reading and the one-entry output queue
`timescale 1ns/10ps
module sms_reading_store #(
    parameter int unsigned RDG_W = 32
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic conv_done_i,
    input wire logic [RDG_W-1:0] conv_data_i,
    input wire logic fetch_i,
    input wire logic func_q_i,
    input wire logic [1:0] func_i,
    input wire logic pop_i,
    output logic [RDG_W-1:0] queue_o,
    output logic mav_o,
    output logic fresh_o
);
    logic [RDG_W-1:0] latest_ff;

    generate
        if (RDG_W < 2 || RDG_W > 32) begin : g_bad_width
            $error("reading width must be 2 to 32");
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latest_ff <= '0;
            fresh_o <= 1'b0;
        end else if (conv_done_i) begin
            latest_ff <= conv_data_i;
            fresh_o <= 1'b1;
        end else if (fetch_i) begin
            fresh_o <= 1'b0;
        end
    end

    // fetch queues the latest reading, stale or not; only the fresh flag also clears
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            queue_o <= '0;
            mav_o <= 1'b0;
        end else if (fetch_i) begin
            queue_o <= latest_ff; // R1 R2
            mav_o <= 1'b1;
        end else if (func_q_i) begin
            queue_o <= {{(RDG_W-2){1'b0}}, func_i}; // R9
            mav_o <= 1'b1;
        end else if (pop_i) begin
            mav_o <= 1'b0;
        end
    end
endmodule

// [test/sms_conv_model.sv]
// converter stand-in: answers each start with one reading after a fixed latency
`timescale 1ns/10ps
module sms_conv_model (
    input wire logic clk_i,
    input wire logic start_i,
    output logic done_o,
    output logic [31:0] data_o
);
    logic [3:0] cnt_ff = 4'h0;
    logic [31:0] num_ff = 32'h0000_0000;
    initial done_o = 1'b0;
    initial data_o = 32'h5555_aaaa;
    // data toggles outside the done pulse so a stale sample never looks valid
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (start_i) begin
            cnt_ff <= 4'h4;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
        if (cnt_ff == 4'h1) begin
            done_o <= 1'b1;
            data_o <= 32'h0000_0100 + num_ff;
            num_ff <= num_ff + 32'h0000_0001;
        end
    end
endmodule

// [test/sms_cmd_seq_props.sv]
// port assertions for the command sequencer
`timescale 1ns/10ps
module sms_cmd_seq_props (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic conv_done_i,
    input wire logic conv_start_o,
    input sms_pkg::sms_setup_t setup_o,
    input wire logic store_abort_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    zero_wait_a: assert property (hreadyout_o) else $error("wait state seen");
    okay_resp_a: assert property (!hresp_o) else $error("error response seen");
    conv_pulse_a: assert property (conv_start_o |=> !conv_start_o) else $error("long start");
    store_pulse_a: assert property (store_abort_o |=> !store_abort_o) else $error("long abort");
    cont_clear_a: assert property (store_abort_o |-> !setup_o.cont_init) else $error("cont kept");
    math_buf_off_a: assert property (store_abort_o |-> !setup_o.math_en && !setup_o.buf_en)
        else $error("math or buffer kept");
    az_default_a: assert property (store_abort_o |-> setup_o.az_en && !setup_o.acq_avg && !setup_o.scan_en)
        else $error("autozero or scan kept");
    one_shot_idle_a: assert property (conv_done_i && !setup_o.cont_init |=> !conv_start_o [*3])
        else $error("rearmed");
endmodule
bind sms_cmd_seq sms_cmd_seq_props sms_cmd_seq_props_inst (.clk_i, .rstn_i, .hreadyout_o, .hresp_o,
    .conv_done_i, .conv_start_o, .setup_o, .store_abort_o);

// [test/test_sms_cmd_seq.sv]
// self-checking bench for the command sequencer
`timescale 1ns/10ps
module test_sms_cmd_seq;
    logic clk_i, rstn_i, hsel, hwrite, hrdy, done, start, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, cdata, q;
    int bad_count = 0;
    int cmp_count = 0;
    sms_cmd_seq sms_cmd_seq_inst (.clk_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(), .conv_done_i(done), .conv_data_i(cdata), .ext_trig_i(1'b0),
        .conv_start_o(start), .setup_o(), .store_abort_o(), .irq_o(irq));
    sms_conv_model sms_conv_model_inst (.clk_i, .start_i(start), .done_o(done), .data_o(cdata));
    task automatic results();
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] id, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %h expected %h seen %h", id, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, q);
        chk(a, q, e);
    endtask
    // issue a command and poll busy until the sequencer is free
    task automatic cmd(input logic [31:0] c);
        wr(sms_pkg::OFS_CMD, c);
        q = 32'h0000_0001;
        for (int i = 0; i < 60 && q[0] !== 1'b0; i++) bus(1'b0, sms_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(8'h14, q & 32'h0000_0001, 32'h0000_0000);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        results();
    end
    initial begin
        {rstn_i, hsel, hwrite, htrans, hwdata, haddr} = '0;
        hsize = 3'b010;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(8'h40, 32'h0000_0000);
        rd(sms_pkg::OFS_SETUP, 32'h0000_0020);
        for (int f = 0; f < 4; f++) begin
            wr(sms_pkg::OFS_SETUP, 32'h0000_0FD8);
            wr(sms_pkg::OFS_TSRC, 32'h0000_0007);
            wr(sms_pkg::OFS_TCNT, 32'h0003_0405);
            wr(sms_pkg::OFS_TDLY, 32'h0009_0909);
            cmd({26'h000_0000, f[1:0], 4'h2});
            rd(sms_pkg::OFS_SETUP, {30'h0000_0008, f[1:0]});
            rd(sms_pkg::OFS_TSRC, 32'h0000_0000);
            rd(sms_pkg::OFS_TCNT, 32'h0001_0101);
            rd(sms_pkg::OFS_TDLY, 32'h0000_0000);
            cmd({26'h000_0000, f[1:0], 4'h7});
            rd(sms_pkg::OFS_DATA, {30'h0000_0000, f[1:0]});
        end
        for (int k = 0; k < 2; k++) begin
            cmd(32'h0000_0003);
            rd(sms_pkg::OFS_DATA, 32'h0000_0100 + 32'(k));
        end
        repeat (2) begin
            cmd(32'h0000_0001);
            rd(sms_pkg::OFS_DATA, 32'h0000_0101);
        end
        rd(sms_pkg::OFS_SETUP, 32'h0000_0023);
        cmd(32'h0000_0014);
        rd(sms_pkg::OFS_SETUP, 32'h0000_0021);
        rd(sms_pkg::OFS_DATA, 32'h0000_0102);
        rd(sms_pkg::OFS_STATUS, 32'h0000_0012);
        wr(sms_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        wr(sms_pkg::OFS_SETUP, 32'h0000_0025);
        cmd(32'h0000_0006);
        bus(1'b0, sms_pkg::OFS_IRQ_STAT, 32'h0000_0000, q);
        chk(8'h1c, q & 32'h0000_0002, 32'h0000_0002);
        chk(8'hff, {31'h0000_0000, irq}, 32'h0000_0000);
        wr(sms_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk_i);
        chk(8'hff, {31'h0000_0000, irq}, 32'h0000_0001);
        wr(sms_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge clk_i);
        chk(8'hff, {31'h0000_0000, irq}, 32'h0000_0000);
        cmd(32'h0000_0003);
        bus(1'b0, sms_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(8'h14, q & 32'h0000_0004, 32'h0000_0004);
        rd(sms_pkg::OFS_DATA, 32'h0000_0102);
        cmd(32'h0000_0005);
        chk(8'h14, q & 32'h0000_0002, 32'h0000_0000);
        cmd(32'h0000_0002);
        rd(sms_pkg::OFS_SETUP, 32'h0000_0020);
        results();
    end
endmodule
